/* File: hdl/rpmg_pkg.sv */
// Constants for the reference pulse multiplier and electronic gear block.
// Assumes a 100 MHz single clock and an AXI4-Lite register slave.
package rpmg_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MULT = 8'h04;
    localparam logic [7:0] ADDR_NUM = 8'h08;
    localparam logic [7:0] ADDR_DEN = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_POS = 8'h14;
    localparam logic [7:0] ADDR_RES = 8'h18;
    // Control field positions
    localparam int CTRL_SEL_ALLOC = 0;
    localparam int CTRL_OUT_ALLOC = 1;
    localparam int CTRL_JOG = 2;
    localparam int CTRL_TUNE = 3;
    localparam int CTRL_RESTART = 4;
    localparam logic [3:0] CTRL_RST = 4'h0;
    // Multiplier setting range and reset value
    localparam logic [6:0] MULT_MIN = 7'h01;
    localparam logic [6:0] MULT_MAX = 7'h64;
    localparam logic [6:0] MULT_RST = 7'h01;
    // Gear ratio limits and reset values
    localparam logic [30:0] GEAR_MIN = 31'h0000_0001;
    localparam logic [30:0] GEAR_MAX = 31'h4000_0000;
    localparam logic [30:0] NUM_RST = 31'h0000_0004;
    localparam logic [30:0] DEN_RST = 31'h0000_0001;
    localparam logic [9:0] RATIO_LO_INV = 10'h3E8;
    localparam logic [11:0] RATIO_HI = 12'hFA0;
    // Encoder resolutions in counts per revolution
    localparam logic [31:0] RES_20 = 32'h0010_0000;
    localparam logic [31:0] RES_17 = 32'h0002_0000;
    localparam logic [31:0] RES_13 = 32'h0000_2000;
    // Divider length and bus answers
    localparam logic [5:0] DIV_STEPS = 6'h26;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Divider states, Gray along idle, divide, done
    typedef enum logic [1:0] {G_IDLE = 2'b00, G_DIV = 2'b01, G_DONE = 2'b11} rpmg_gstate_t;
endpackage

/* File: hdl/rpmg_gear_if.sv */
// Carrier between the pulse front end and the gear divider.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface rpmg_gear_if;
    logic req;
    logic fwd;
    logic [6:0] units;
    logic [30:0] num;
    logic [30:0] den;
    logic clr;
    logic ready;
    logic done;
    logic q_fwd;
    logic [37:0] q;
    modport ctl (output req, fwd, units, num, den, clr, input ready, done, q_fwd, q);
    modport eng (input req, fwd, units, num, den, clr, output ready, done, q_fwd, q);
endinterface

/* File: hdl/rpmg_gear.sv */
// Electronic gear divider: units*num/den with the remainder carried forward.
// Assumes req only while ready, and num/den stable while a division runs.
`timescale 1ns/10ps
module rpmg_gear (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Request and result
    rpmg_gear_if.eng gif
);
    rpmg_pkg::rpmg_gstate_t st_ff;
    logic [37:0] acc_ff;
    logic [38:0] rw_ff;
    logic [30:0] rem_ff;
    logic fwd_ff;
    logic [5:0] cnt_ff;
    logic [37:0] prod;
    logic [37:0] x_in;
    logic [38:0] rw_n;
    logic ge;

    // ==========================================================
    // Dividend: reverse steps use the mirrored remainder so the count floors
    assign prod = 38'(gif.units) * 38'(gif.num);
    assign x_in = gif.fwd ? prod + 38'(rem_ff) : prod + 38'(gif.den - 31'h1 - rem_ff);
    assign rw_n = {rw_ff[37:0], acc_ff[37]};
    assign ge = rw_n >= 39'(gif.den);
    assign gif.ready = st_ff == rpmg_pkg::G_IDLE;
    assign gif.done = st_ff == rpmg_pkg::G_DONE;
    assign gif.q = acc_ff;
    assign gif.q_fwd = fwd_ff;

    // Restoring division, one quotient bit per cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn || gif.clr)
        begin
            st_ff <= rpmg_pkg::G_IDLE;
            acc_ff <= 38'h0;
            rw_ff <= 39'h0;
            fwd_ff <= 1'b0;
            cnt_ff <= 6'h0;
        end
        else
        begin
            case (st_ff)
                rpmg_pkg::G_IDLE:
                begin
                    if (gif.req)
                    begin
                        acc_ff <= x_in;
                        rw_ff <= 39'h0;
                        fwd_ff <= gif.fwd;
                        cnt_ff <= rpmg_pkg::DIV_STEPS;
                        st_ff <= rpmg_pkg::G_DIV;
                    end
                end
                rpmg_pkg::G_DIV:
                begin
                    rw_ff <= ge ? rw_n - 39'(gif.den) : rw_n;
                    acc_ff <= {acc_ff[36:0], ge};
                    cnt_ff <= cnt_ff - 6'h1;
                    if (cnt_ff == 6'h1)
                    begin
                        st_ff <= rpmg_pkg::G_DONE;
                    end
                end
                rpmg_pkg::G_DONE: st_ff <= rpmg_pkg::G_IDLE;
                default: st_ff <= rpmg_pkg::G_IDLE;
            endcase
        end
    end

    // Carried remainder, cleared only by reset or restart
    always_ff @(posedge aclk)
    begin
        if (!aresetn || gif.clr)
        begin
            rem_ff <= 31'h0;
        end
        else if (st_ff == rpmg_pkg::G_DONE)
        begin
            rem_ff <= fwd_ff ? rw_ff[30:0] : gif.den - 31'h1 - rw_ff[30:0];
        end
    end

    AST_DIV_TIME: assert property (@(posedge aclk) disable iff (!aresetn || gif.clr)
        gif.req && gif.ready |-> ##39 gif.done) else $error("divider result late");
    AST_REM_BOUND: assert property (@(posedge aclk) disable iff (!aresetn || gif.clr)
        gif.done |=> rem_ff < gif.den) else $error("carried remainder not below den");
endmodule

/* File: hdl/rpmg_top.sv */
// Reference pulse multiplier and electronic gear, with an AXI4-Lite slave.
// Assumes pins are asynchronous to aclk and each reference pulse is a high level
// on ref_pulse_in lasting more than two clock cycles.
`timescale 1ns/10ps
module rpmg_top #(
    parameter int ENC_BITS = 20,
    parameter int PEND_W = 10
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic ref_pulse_in,
    input wire logic ref_sign_in,
    input wire logic mult_select_in,
    output logic mult_active_out,
    output logic gear_alarm_out,
    output logic [31:0] enc_pos
);
    rpmg_gear_if gif ();

    // Encoder resolution for the fitted encoder
    localparam logic [31:0] ENC_RES = (ENC_BITS == 20) ? rpmg_pkg::RES_20 :
        (ENC_BITS == 17) ? rpmg_pkg::RES_17 : rpmg_pkg::RES_13;

    logic aw_rdy_ff, w_rdy_ff, bvalid_ff, ar_rdy_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [3:0] ctrl_ff;
    logic restart_ff;
    logic [6:0] mult_value_setting;
    logic [30:0] num_sh_ff, den_sh_ff, gear_numerator, gear_denominator;
    logic alarm_ff;
    logic [2:0] pin_s1_ff, pin_s2_ff;
    logic pulse_s3_ff;
    logic signed [PEND_W-1:0] pend_ff;
    logic req_ff, fwd_ff;
    logic [6:0] units_ff;
    logic mult_on_ff, act_out_ff;
    logic [31:0] pos_ff;
    logic wr_fire, rd_fire, step_in, take, idle, frz, sel_req;
    logic [31:0] wd, cur, rd_val;
    logic rd_hit, wr_hit;
    logic [40:0] num_x;
    logic [42:0] den_x;

    // ==========================================================
    // Bus slave
    // Byte lanes not strobed keep the register's old contents
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] stb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (stb[i])
            begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    assign wr_fire = aw_rdy_ff && w_rdy_ff && s_axi_awvalid && s_axi_wvalid;
    assign rd_fire = ar_rdy_ff && s_axi_arvalid;

    // Readback mux shared by reads and write merging
    function automatic logic [31:0] regval(input logic [7:0] a, input logic [31:0] st_w);
        case (a)
            rpmg_pkg::ADDR_CTRL: regval = {28'h0, ctrl_ff};
            rpmg_pkg::ADDR_MULT: regval = {25'h0, mult_value_setting};
            rpmg_pkg::ADDR_NUM: regval = {1'b0, num_sh_ff};
            rpmg_pkg::ADDR_DEN: regval = {1'b0, den_sh_ff};
            rpmg_pkg::ADDR_STAT: regval = st_w;
            rpmg_pkg::ADDR_POS: regval = pos_ff;
            rpmg_pkg::ADDR_RES: regval = ENC_RES;
            default: regval = 32'h0;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= rpmg_pkg::ADDR_RES);
    endfunction

    // Mux in a process: it must re-run when a register changes, not only the address
    always_comb
    begin
        cur = regval(s_axi_awaddr, 32'h0);
        rd_val = regval(s_axi_araddr, {29'h0, ~gif.ready, alarm_ff, mult_on_ff});
    end
    assign wd = merge(cur, s_axi_wdata, s_axi_wstrb);
    assign wr_hit = mapped(s_axi_awaddr);
    assign rd_hit = mapped(s_axi_araddr);

    // Write channel: ready one cycle after both address and data are offered
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_rdy_ff <= 1'b0;
            w_rdy_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= rpmg_pkg::RESP_OKAY;
        end
        else
        begin
            aw_rdy_ff <= s_axi_awvalid && s_axi_wvalid && !aw_rdy_ff && !bvalid_ff;
            w_rdy_ff <= s_axi_awvalid && s_axi_wvalid && !w_rdy_ff && !bvalid_ff;
            if (wr_fire)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? rpmg_pkg::RESP_OKAY : rpmg_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Read channel: data registered, unmapped addresses answer SLVERR
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ar_rdy_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= rpmg_pkg::RESP_OKAY;
        end
        else
        begin
            ar_rdy_ff <= s_axi_arvalid && !ar_rdy_ff && !rvalid_ff;
            if (rd_fire)
            begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_val;
                rresp_ff <= rd_hit ? rpmg_pkg::RESP_OKAY : rpmg_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready)
            begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Settings
    // Control bits; restart is a self-clearing pulse
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_ff <= rpmg_pkg::CTRL_RST;
            restart_ff <= 1'b0;
        end
        else
        begin
            restart_ff <= wr_fire && s_axi_awaddr == rpmg_pkg::ADDR_CTRL
                && wd[rpmg_pkg::CTRL_RESTART];
            if (wr_fire && s_axi_awaddr == rpmg_pkg::ADDR_CTRL)
            begin
                ctrl_ff <= wd[3:0];
            end
        end
    end

    // Multiplier setting: out-of-range writes are dropped, no restart needed
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mult_value_setting <= rpmg_pkg::MULT_RST;
        end
        else if (wr_fire && s_axi_awaddr == rpmg_pkg::ADDR_MULT && wd[31:7] == 25'h0
            && wd[6:0] >= rpmg_pkg::MULT_MIN && wd[6:0] <= rpmg_pkg::MULT_MAX)
        begin
            mult_value_setting <= wd[6:0];
        end
    end

    // Gear shadows accept 1..2^30; they reach the divider only on restart
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            num_sh_ff <= rpmg_pkg::NUM_RST;
            den_sh_ff <= rpmg_pkg::DEN_RST;
        end
        else if (wr_fire && wd[31] == 1'b0 && wd[30:0] >= rpmg_pkg::GEAR_MIN
            && wd[30:0] <= rpmg_pkg::GEAR_MAX)
        begin
            if (s_axi_awaddr == rpmg_pkg::ADDR_NUM)
            begin
                num_sh_ff <= wd[30:0];
            end
            if (s_axi_awaddr == rpmg_pkg::ADDR_DEN)
            begin
                den_sh_ff <= wd[30:0];
            end
        end
    end

    // Active gear ratio, fixed between restarts
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gear_numerator <= rpmg_pkg::NUM_RST;
            gear_denominator <= rpmg_pkg::DEN_RST;
        end
        else if (restart_ff)
        begin
            gear_numerator <= num_sh_ff;
            gear_denominator <= den_sh_ff;
        end
    end

    // Ratio check without division: num*1000 >= den and num <= den*4000
    assign num_x = 41'(gear_numerator) * 41'(rpmg_pkg::RATIO_LO_INV);
    assign den_x = 43'(gear_denominator) * 43'(rpmg_pkg::RATIO_HI);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            alarm_ff <= 1'b0;
        end
        else
        begin
            alarm_ff <= num_x < 41'(gear_denominator) || 43'(gear_numerator) > den_x;
        end
    end

    // ==========================================================
    // Pin synchronisers: pulse, sign, select
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_s1_ff <= 3'h0;
            pin_s2_ff <= 3'h0;
            pulse_s3_ff <= 1'b0;
        end
        else
        begin
            pin_s1_ff <= {mult_select_in, ref_sign_in, ref_pulse_in};
            pin_s2_ff <= pin_s1_ff;
            pulse_s3_ff <= pin_s2_ff[0];
        end
    end

    assign step_in = pin_s2_ff[0] && !pulse_s3_ff;
    assign sel_req = ctrl_ff[rpmg_pkg::CTRL_SEL_ALLOC] && pin_s2_ff[2];
    assign frz = ctrl_ff[rpmg_pkg::CTRL_JOG] || ctrl_ff[rpmg_pkg::CTRL_TUNE];
    assign take = pend_ff != '0 && gif.ready && !req_ff && !alarm_ff;
    assign idle = pend_ff == '0 && gif.ready && !req_ff && !step_in;

    // ==========================================================
    // Pending pulses: signed net count so no edge is lost while dividing
    always_ff @(posedge aclk)
    begin
        if (!aresetn || restart_ff)
        begin
            pend_ff <= '0;
        end
        else
        begin
            pend_ff <= pend_ff + (step_in ? (pin_s2_ff[1] ? PEND_W'(1) : -PEND_W'(1)) : '0)
                - (take ? (pend_ff[PEND_W-1] ? -PEND_W'(1) : PEND_W'(1)) : '0);
        end
    end

    // One request per pulse, carrying n or 1 reference units
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            req_ff <= 1'b0;
            fwd_ff <= 1'b0;
            units_ff <= rpmg_pkg::MULT_MIN;
        end
        else
        begin
            req_ff <= take;
            if (take)
            begin
                fwd_ff <= !pend_ff[PEND_W-1];
                units_ff <= mult_on_ff ? mult_value_setting : rpmg_pkg::MULT_MIN;
            end
        end
    end

    // Multiplier switch only between pulses, and never while a utility runs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mult_on_ff <= 1'b0;
        end
        else if (idle && !frz)
        begin
            mult_on_ff <= sel_req;
        end
    end

    // Status pin follows one cycle after the switch, only when allocated
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            act_out_ff <= 1'b0;
        end
        else
        begin
            act_out_ff <= ctrl_ff[rpmg_pkg::CTRL_OUT_ALLOC] && mult_on_ff;
        end
    end

    // Encoder position accumulates each quotient, wrapping at 32 bits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pos_ff <= 32'h0;
        end
        else if (gif.done)
        begin
            pos_ff <= gif.q_fwd ? pos_ff + gif.q[31:0] : pos_ff - gif.q[31:0];
        end
    end

    // ==========================================================
    // Divider and outputs
    assign gif.req = req_ff;
    assign gif.fwd = fwd_ff;
    assign gif.units = units_ff;
    assign gif.num = gear_numerator;
    assign gif.den = gear_denominator;
    assign gif.clr = restart_ff;

    rpmg_gear u_gear (
        .aclk(aclk),
        .aresetn(aresetn),
        .gif(gif)
    );

    assign s_axi_awready = aw_rdy_ff;
    assign s_axi_wready = w_rdy_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = ar_rdy_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign mult_active_out = act_out_ff;
    assign gear_alarm_out = alarm_ff;
    assign enc_pos = pos_ff;

    // ==========================================================
    // Checks
    sequence s_switch_on;
        !mult_on_ff && sel_req && idle && !frz;
    endsequence
    sequence s_status_on;
        mult_on_ff ##1 (act_out_ff == ctrl_ff[rpmg_pkg::CTRL_OUT_ALLOC]);
    endsequence

    AST_SWITCH_STATUS: assert property (@(posedge aclk) disable iff (!aresetn)
        s_switch_on |=> s_status_on) else $error("status did not follow switch");
    AST_FREEZE: assert property (@(posedge aclk) disable iff (!aresetn)
        frz |=> $stable(mult_on_ff)) else $error("switch during utility");
    AST_BETWEEN: assert property (@(posedge aclk) disable iff (!aresetn)
        !idle |=> $stable(mult_on_ff)) else $error("switch during pulse");
    AST_UNITS: assert property (@(posedge aclk) disable iff (!aresetn)
        take ##1 req_ff |-> units_ff == (mult_on_ff ? mult_value_setting : 7'h01))
        else $error("wrong unit count");
    AST_MULT_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
        mult_value_setting >= 7'h01 && mult_value_setting <= 7'h64)
        else $error("multiplier out of range");
    AST_GEAR_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        !restart_ff |=> $stable(gear_numerator) && $stable(gear_denominator))
        else $error("gear changed without restart");
    AST_ALARM_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
        alarm_ff |=> !req_ff) else $error("pulse passed under alarm");
    AST_POS_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
        gif.done && gif.q_fwd |=> pos_ff == $past(pos_ff) + $past(gif.q[31:0]))
        else $error("position not advanced by quotient");
    AST_BRESP: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire |=> bvalid_ff ##0 !aw_rdy_ff) else $error("write not answered");
endmodule

/* File: dv/rpmg_host_model.sv */
// Host controller model: issues reference pulses and drives the select pin.
// Assumes the bench calls one task at a time, off the same aclk as the device.
`timescale 1ns/10ps
module rpmg_host_model (
    // Clock
    input wire logic aclk,
    // Status from the device
    input wire logic mult_active_out,
    // Pins towards the device
    output logic ref_pulse_in,
    output logic ref_sign_in,
    output logic mult_select_in
);
    // ==========================================================
    // Pin drivers, idle low with forward direction
    initial
    begin
        ref_pulse_in = 1'h0;
        ref_sign_in = 1'h1;
        mult_select_in = 1'h0;
    end
    // Sign settles first; pulses stay 4 high and 3 low for the pin synchroniser
    task automatic send(input int k, input logic fwd);
        repeat (4) @(posedge aclk);
        ref_sign_in <= fwd;
        repeat (k)
        begin
            repeat (3) @(posedge aclk);
            ref_pulse_in <= 1'h1;
            repeat (4) @(posedge aclk);
            ref_pulse_in <= 1'h0;
        end
    endtask
    // Called only with no pulse in flight; bounded wait for the status
    task automatic select(input logic on);
        @(posedge aclk);
        mult_select_in <= on;
        for (int i = 0; i < 16 && mult_active_out !== on; i++) @(posedge aclk);
    endtask
endmodule

/* File: dv/tb_rpmg_top.sv */
// Self-checking bench for the pulse multiplier and gear block.
// Assumes the host model drives the pins and AXI4-Lite is driven here.
`timescale 1ns/10ps
module tb_rpmg_top;
    // ==========================================================
    // Signals and bench state
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, enc_pos, seed = 32'h7ADC645D;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic ref_pulse_in, ref_sign_in, mult_select_in, mult_active_out, gear_alarm_out;
    int fails = 0, cmp_count = 0;
    longint units = 0, base = 0, num = 4, den = 1, m = 1, n;
    longint lim [4][3] = '{'{4001, 1, 1}, '{1, 1001, 1}, '{1, 1000, 0}, '{4000, 1, 0}};
    // Clock
    always #5 aclk = ~aclk;
    // ==========================================================
    // Device and host
    rpmg_top i_rpmg_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ref_pulse_in,
        .ref_sign_in, .mult_select_in, .mult_active_out, .gear_alarm_out, .enc_pos);
    rpmg_host_model i_rpmg_host_model (.aclk, .mult_active_out, .ref_pulse_in,
        .ref_sign_in, .mult_select_in);
    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Floor of units times ratio, so reverse travel rounds down too
    function automatic longint exp_pos(input longint u, input longint nm, input longint dn);
        longint p;
        p = u * nm;
        exp_pos = p / dn;
        if (p < 0 && exp_pos * dn != p)
            exp_pos -= 1;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        rr = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        rr = s_axi_rresp;
        chk(s_axi_rdata, e);
    endtask
    // Pulses through the host, then a wait long enough for every division
    task automatic conv(input int k, input logic fwd);
        i_rpmg_host_model.send(k, fwd);
        units += (fwd ? k : -k) * m;
        repeat (k * 42 + 60) @(posedge aclk);
        chk(enc_pos, 32'(base + exp_pos(units, num, den)));
    endtask
    // Position is kept across a restart, the remainder is not
    task automatic restart(input longint nn, input longint dd);
        base += exp_pos(units, num, den);
        units = 0;
        num = nn;
        den = dd;
        wr(rpmg_pkg::ADDR_NUM, 32'(nn));
        wr(rpmg_pkg::ADDR_DEN, 32'(dd));
        wr(rpmg_pkg::ADDR_CTRL, 32'h13);
        repeat (4) @(posedge aclk);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ==========================================================
    // Watchdog, far beyond the few thousand cycles the tests need
    initial
    begin
        #400000;
        fails++;
        $display("BAD %0t watchdog expired", $time);
        results;
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        rd(rpmg_pkg::ADDR_CTRL, 32'h0);
        rd(rpmg_pkg::ADDR_MULT, 32'h1);
        rd(rpmg_pkg::ADDR_NUM, 32'h4);
        rd(rpmg_pkg::ADDR_DEN, 32'h1);
        rd(rpmg_pkg::ADDR_RES, rpmg_pkg::RES_20);
        rd(8'h1C, 32'h0);
        chk(32'(rr), 32'(rpmg_pkg::RESP_SLVERR));
        wr(8'h1C, 32'h0);
        chk(32'(rr), 32'(rpmg_pkg::RESP_SLVERR));
        $display("reset test done");
        // Unity multiplier, then a random n with an out of range write ignored
        conv(5, 1'h1);
        rd(rpmg_pkg::ADDR_POS, 32'h14);
        seed = lfsr(seed);
        n = seed % 100 + 1;
        wr(rpmg_pkg::ADDR_MULT, 32'(n));
        wr(rpmg_pkg::ADDR_MULT, 32'h65);
        rd(rpmg_pkg::ADDR_MULT, 32'(n));
        wr(rpmg_pkg::ADDR_CTRL, 32'h3);
        i_rpmg_host_model.select(1'h1);
        chk(32'(mult_active_out), 32'h1);
        m = n;
        conv(3, 1'h1);
        conv(2, 1'h0);
        i_rpmg_host_model.select(1'h0);
        chk(32'(mult_active_out), 32'h0);
        m = 1;
        conv(2, 1'h1);
        $display("multiplier test done");
        // Random fractional gears, all three driven in reverse by this seed
        repeat (3)
        begin
            seed = lfsr(seed);
            restart(seed[7:0] % 50 + 1, seed[15:8] % 50 + 1);
            chk(32'(gear_alarm_out), 32'h0);
            conv(seed[18:16] + 1, seed[19]);
        end
        // Ratio limits on both sides of each bound
        foreach (lim[i])
        begin
            restart(lim[i][0], lim[i][1]);
            chk(32'(gear_alarm_out), 32'(lim[i][2]));
        end
        conv(2, 1'h1);
        $display("gear test done");
        // Switching frozen while a utility runs; output needs its allocation
        wr(rpmg_pkg::ADDR_CTRL, 32'h7);
        i_rpmg_host_model.select(1'h1);
        rd(rpmg_pkg::ADDR_STAT, 32'h0);
        wr(rpmg_pkg::ADDR_CTRL, 32'hB);
        rd(rpmg_pkg::ADDR_STAT, 32'h0);
        wr(rpmg_pkg::ADDR_CTRL, 32'h1);
        repeat (4) @(posedge aclk);
        chk(32'(mult_active_out), 32'h0);
        rd(rpmg_pkg::ADDR_STAT, 32'h1);
        wr(rpmg_pkg::ADDR_CTRL, 32'h3);
        repeat (3) @(posedge aclk);
        chk(32'(mult_active_out), 32'h1);
        $display("select test done");
        results;
    end
endmodule
